// ### bhcs_consts.svh
// Purpose: shared constants for the bus-hold / chip-select / clock-out block
// Assumes: 24-bit internal address space, six chip selects
// Notes:   definitions only
`ifndef BHCS_CONSTS_SVH
`define BHCS_CONSTS_SVH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define BHCS_ADDR_W 24
`define BHCS_CS_N 6
`define BHCS_SEL_W 3
`define BHCS_SYNC_W 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define BHCS_CS0_BASE 24'hff_2000
`define BHCS_CS0_TOP 24'hff_20ff
`define BHCS_ADDR_ZERO 24'h00_0000
`define BHCS_DEFAULT_SEL 3'h5

`endif

// ### bhcs_pkg.sv
// Purpose: types for the bus-hold / chip-select / clock-out block
// Assumes: nothing
// Notes:   constants live in bhcs_consts.svh
package bhcs_pkg;

    // ----------------------------------------
    // bus ownership states
    // ----------------------------------------
    typedef enum logic {
        BHCS_OWN,
        BHCS_HELD
    } bhcs_hold_state_t;

endpackage : bhcs_pkg

// ### bhcs_dec_if.sv
// Purpose: carries range settings and decode results between top and decoder
// Assumes: settings are held in flip-flops of the top module
// Notes:   match is raw per-range hit, hit includes remapping
`timescale 1ns/100ps
`include "bhcs_consts.svh"

interface bhcs_dec_if #(
    parameter int ADDR_W = `BHCS_ADDR_W,
    parameter int CS_N = `BHCS_CS_N
);
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] base [CS_N];
    logic [ADDR_W-1:0] top [CS_N];
    logic [CS_N-1:0] en;
    logic [CS_N-1:0] remap;
    logic [CS_N-1:0] match;
    logic [CS_N-1:0] hit;
    logic [`BHCS_SEL_W-1:0] sel;

    // ----------------------------------------
    // decoder and owner views
    // ----------------------------------------
    modport dec (
        input addr, base, top, en, remap,
        output match, hit, sel
    );
    modport own (
        output addr, base, top, en, remap,
        input match, hit, sel
    );
endinterface : bhcs_dec_if

// ### bhcs_cs_decode.sv
// Purpose: address range decode for the chip-select outputs
// Assumes: ranges are inclusive, base not above top
// Notes:   purely combinational
`timescale 1ns/100ps
`include "bhcs_consts.svh"

module bhcs_cs_decode #(
    parameter int CS_N = `BHCS_CS_N
) (
    // decode carrier
    bhcs_dec_if.dec d
);

    // ----------------------------------------
    // per-range match and remap
    // ----------------------------------------
    for (genvar x = 0; x < CS_N; x++) begin : g_cs
        // [R8] range compare
        assign d.match[x] = d.en[x] && (d.addr >= d.base[x]) && (d.addr <= d.top[x]);
        if (x < CS_N - 1) begin : g_rm
            // [R9] next range remap
            assign d.hit[x] = d.match[x] || (d.remap[x] && d.match[x+1]);
        end else begin : g_last
            assign d.hit[x] = d.match[x];
        end
    end

    // lowest matching range picks bus config
    always_comb begin
        // [R10] default to five
        d.sel = `BHCS_DEFAULT_SEL;
        for (int i = CS_N - 1; i >= 0; i--) begin
            if (d.match[i]) begin
                d.sel = i[`BHCS_SEL_W-1:0];
            end
        end
    end

endmodule : bhcs_cs_decode

// ### bhcs_top.sv
// Purpose: bus-hold handshake, chip-select outputs and half-rate clock out
// Assumes: core signals are on clock_i; hold request arrives from a pin
// Notes:   all outputs registered; one cycle from core request to pins
`timescale 1ns/100ps
`include "bhcs_consts.svh"

// What this block does
// [R1] In hold, bus request asserts while an external cycle is pending.
// [R2] Hold protocol enabled: shared port pin carries only the bus request.
// [R3] Port pin configuration writes are ignored while hold protocol is enabled.
// [R4] Bus request never asserts before hold acknowledge.
// [R5] Bus request stays asserted until the master drops its hold request.
// [R6] Clock output runs at half the internal clock.
// [R7] Clock output has equal high and low times.
// [R8] During an external cycle, the matching range's chip select goes low.
// [R9] With remap on, select x also answers range x plus one.
// [R10] No range matches: no select asserted, bus config from select five.
// [R11] After reset select zero covers ff2000 through ff20ff.
// [R12] Each select has software-written base, top, enable and remap settings.
// [R13] Hold acknowledge asserts low once the bus is released to the master.
// [R14] The master holds its request low as long as it needs the bus.
module bhcs_top #(
    parameter int ADDR_W = `BHCS_ADDR_W,
    parameter int CS_N = `BHCS_CS_N
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // hold handshake pins
    input wire logic hold_req_n_i,
    output logic hold_ack_out_n_o,
    output logic bus_request_out_n_o,
    // core bus controller
    input wire logic hold_protocol_enable_i,
    input wire logic ext_cycle_pending_i,
    input wire logic ext_cycle_active_i,
    input wire logic [ADDR_W-1:0] ext_addr_i,
    // port 2 bit 3 configuration and pin
    input wire logic port2_cfg_wr_i,
    input wire logic port2_function_select_i,
    input wire logic port2_direction_i,
    input wire logic port2_output_latch_i,
    output logic port2_bit3_pin_o,
    output logic port2_bit3_pin_oe_o,
    // chip-select range settings
    input wire logic cs_cfg_wr_i,
    input wire logic [`BHCS_SEL_W-1:0] cs_cfg_idx_i,
    input wire logic [ADDR_W-1:0] cs_cfg_base_i,
    input wire logic [ADDR_W-1:0] cs_cfg_top_i,
    input wire logic cs_cfg_en_i,
    input wire logic cs_cfg_remap_i,
    // chip selects, bus config and clock out
    output logic [CS_N-1:0] chip_select_out_n_o,
    output logic [`BHCS_SEL_W-1:0] bus_cfg_sel_o,
    output logic half_rate_clock_out_o
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (CS_N < 2 || CS_N > 6 || ADDR_W != `BHCS_ADDR_W) begin : g_bad
        $error("bhcs_top: CS_N must be 2..6 and ADDR_W must be 24");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [`BHCS_SYNC_W-1:0] hold_sync_r;
    logic hold_seen_r, bus_request_out_n_nxt, cs0_touched_r;
    bhcs_pkg::bhcs_hold_state_t state_r, state_nxt;
    logic p2_func_r, port2_direction_r, p2_latch_r;
    logic [ADDR_W-1:0] base_r [CS_N], top_r [CS_N];
    logic [CS_N-1:0] en_r, remap_r;

    bhcs_dec_if #(.ADDR_W(ADDR_W), .CS_N(CS_N)) dec_bus ();

    // ----------------------------------------
    // hold request synchroniser
    // ----------------------------------------
    // three stages, value taken when stages two and three agree
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_sync_r <= '1;
            hold_seen_r <= 1'b0;
        end else begin
            hold_sync_r <= {hold_sync_r[1:0], hold_req_n_i};
            if (hold_sync_r[1] == hold_sync_r[2]) begin
                hold_seen_r <= ~hold_sync_r[2];
            end
        end
    end

    // ----------------------------------------
    // bus ownership
    // ----------------------------------------
    // release only between external cycles
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bhcs_pkg::BHCS_OWN: begin
                if (hold_protocol_enable_i && hold_seen_r && !ext_cycle_active_i) begin
                    state_nxt = bhcs_pkg::BHCS_HELD;
                end
            end
            bhcs_pkg::BHCS_HELD: begin
                if (!hold_seen_r || !hold_protocol_enable_i) begin
                    state_nxt = bhcs_pkg::BHCS_OWN;
                end
            end
            default: begin
                state_nxt = bhcs_pkg::BHCS_OWN;
            end
        endcase
    end

    // [R4] request only with acknowledge
    // [R5] request held until release
    assign bus_request_out_n_nxt = (state_nxt == bhcs_pkg::BHCS_HELD)
        && (ext_cycle_pending_i || !bus_request_out_n_o);

    // state, acknowledge and request pins
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= bhcs_pkg::BHCS_OWN;
            hold_ack_out_n_o <= 1'b1;
            bus_request_out_n_o <= 1'b1;
        end else begin
            state_r <= state_nxt;
            // [R13] acknowledge on release
            hold_ack_out_n_o <= (state_nxt != bhcs_pkg::BHCS_HELD);
            // [R1] request on pending cycle
            bus_request_out_n_o <= ~bus_request_out_n_nxt;
        end
    end

    // ----------------------------------------
    // port 2 bit 3 shared pin
    // ----------------------------------------
    // [R3] configuration locked while enabled
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            p2_func_r <= 1'b0;
            port2_direction_r <= 1'b0;
            p2_latch_r <= 1'b1;
        end else if (port2_cfg_wr_i && !hold_protocol_enable_i) begin
            p2_func_r <= port2_function_select_i;
            port2_direction_r <= port2_direction_i;
            p2_latch_r <= port2_output_latch_i;
        end
    end

    // [R2] hold protocol overrides port
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port2_bit3_pin_o <= 1'b1;
            port2_bit3_pin_oe_o <= 1'b0;
        end else if (hold_protocol_enable_i || p2_func_r) begin
            port2_bit3_pin_o <= ~bus_request_out_n_nxt;
            port2_bit3_pin_oe_o <= 1'b1;
        end else begin
            port2_bit3_pin_o <= p2_latch_r;
            port2_bit3_pin_oe_o <= port2_direction_r;
        end
    end

    // ----------------------------------------
    // half-rate clock out
    // ----------------------------------------
    // [R6] [R7] toggle, even duty
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_rate_clock_out_o <= 1'b0;
        end else begin
            half_rate_clock_out_o <= ~half_rate_clock_out_o;
        end
    end

    // ----------------------------------------
    // chip-select range settings
    // ----------------------------------------
    // [R12] software range writes
    // [R11] select zero default range
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < CS_N; i++) begin
                base_r[i] <= (i == 0) ? `BHCS_CS0_BASE : `BHCS_ADDR_ZERO;
                top_r[i] <= (i == 0) ? `BHCS_CS0_TOP : `BHCS_ADDR_ZERO;
            end
            en_r <= CS_N'(1);
            remap_r <= '0;
            cs0_touched_r <= 1'b0;
        end else if (cs_cfg_wr_i && (int'(cs_cfg_idx_i) < CS_N)) begin
            base_r[cs_cfg_idx_i] <= cs_cfg_base_i;
            top_r[cs_cfg_idx_i] <= cs_cfg_top_i;
            en_r[cs_cfg_idx_i] <= cs_cfg_en_i;
            remap_r[cs_cfg_idx_i] <= cs_cfg_remap_i;
            if (cs_cfg_idx_i == '0) begin
                cs0_touched_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // decode and chip-select outputs
    // ----------------------------------------
    assign dec_bus.addr = ext_addr_i;
    assign dec_bus.base = base_r;
    assign dec_bus.top = top_r;
    assign dec_bus.en = en_r;
    assign dec_bus.remap = remap_r;

    bhcs_cs_decode #(.CS_N(CS_N)) u_decode (
        .d(dec_bus.dec)
    );

    // [R8] assert only during a cycle
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chip_select_out_n_o <= '1;
            bus_cfg_sel_o <= `BHCS_DEFAULT_SEL;
        end else if (ext_cycle_active_i) begin
            chip_select_out_n_o <= ~dec_bus.hit;
            bus_cfg_sel_o <= dec_bus.sel;
        end else begin
            chip_select_out_n_o <= '1;
            bus_cfg_sel_o <= `BHCS_DEFAULT_SEL;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    bus_request_out_n_after_hold_ack_out_n_a: // [R4]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !bus_request_out_n_o |-> !hold_ack_out_n_o)
        else $error("bus request without hold acknowledge");

    bus_request_out_n_holds_a: // [R5]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!bus_request_out_n_o && hold_seen_r && hold_protocol_enable_i)
        |=> !bus_request_out_n_o)
        else $error("bus request dropped while hold still requested");

    bus_request_out_n_pending_a: // [R1]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!hold_ack_out_n_o && hold_seen_r && hold_protocol_enable_i
        && ext_cycle_pending_i) |=> !bus_request_out_n_o)
        else $error("pending cycle in hold did not raise bus request");

    hold_ack_out_n_release_a: // [R13]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_r == bhcs_pkg::BHCS_OWN && hold_seen_r && hold_protocol_enable_i
        && !ext_cycle_active_i) |=> !hold_ack_out_n_o)
        else $error("hold acknowledge missing after release");

    pin_override_a: // [R2]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        hold_protocol_enable_i |=> port2_bit3_pin_oe_o
        && (port2_bit3_pin_o == bus_request_out_n_o))
        else $error("port pin not carrying bus request");

    cfg_locked_a: // [R3]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        hold_protocol_enable_i |=> $stable(p2_latch_r) && $stable(port2_direction_r)
        && $stable(p2_func_r))
        else $error("port configuration changed while locked");

    half_rate_clock_out_rate_a: // [R6]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        half_rate_clock_out_o |=> !half_rate_clock_out_o ##1 half_rate_clock_out_o)
        else $error("clock out not at half rate");
    half_rate_clock_out_duty_a: // [R7]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(half_rate_clock_out_o) |=> $fell(half_rate_clock_out_o))
        else $error("clock out high time not one cycle");
    cs_decode_a: // [R8]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ext_cycle_active_i |=> chip_select_out_n_o == ~$past(dec_bus.hit))
        else $error("chip selects do not follow decode");
    cs_remap_a: // [R9]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ext_cycle_active_i && remap_r[0] && dec_bus.match[1])
        |=> !chip_select_out_n_o[0] && !chip_select_out_n_o[1])
        else $error("remapped select not asserted");

    cs_nomatch_a: // [R10]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ext_cycle_active_i && dec_bus.match == '0)
        |=> chip_select_out_n_o == '1 && bus_cfg_sel_o == `BHCS_DEFAULT_SEL)
        else $error("unmatched access asserted a select");

    cs0_default_a: // [R11]
    assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ext_cycle_active_i && !cs0_touched_r && !cs_cfg_wr_i
        && ext_addr_i >= `BHCS_CS0_BASE && ext_addr_i <= `BHCS_CS0_TOP)
        |=> !chip_select_out_n_o[0])
        else $error("select zero default range not decoded");

endmodule : bhcs_top

// ### bhcs_master_model.sv
// Purpose: external bus master that drives the hold request pin
// Assumes: the bench says when the master wants the bus
// Notes:   the pin changes just after a rising edge
`timescale 1ns/100ps

module bhcs_master_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // bench control
    input wire logic want_bus_i,
    // hold request pin
    output logic hold_req_n_o
);
    // ----------------------------------------
    // hold request
    // ----------------------------------------
    // low while bus wanted
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_req_n_o <= 1'b1;
        end else begin
            hold_req_n_o <= ~want_bus_i;
        end
    end
endmodule : bhcs_master_model

// ### bhcs_top_tb.sv
// Purpose: self-checking bench for the hold, chip-select and clock-out block
// Assumes: inputs change at the falling edge
// Notes:   expectations follow the reset ranges and the hold handshake
`timescale 1ns/100ps
`include "bhcs_consts.svh"

module bhcs_top_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic hold_req_n_i, want_bus = 1'b0;
    logic hold_ack_out_n_o, bus_request_out_n_o;
    logic hold_protocol_enable_i = 1'b0;
    logic ext_cycle_pending_i = 1'b0;
    logic ext_cycle_active_i = 1'b0;
    logic [23:0] ext_addr_i = 24'h00_0000;
    logic port2_cfg_wr_i = 1'b0, p2_func = 1'b0, port2_direction = 1'b0, p2_latch = 1'b0;
    logic port2_bit3_pin_o, port2_bit3_pin_oe_o;
    logic cs_cfg_wr_i = 1'b0, cs_cfg_en_i = 1'b0, cs_cfg_remap_i = 1'b0;
    logic [2:0] cs_cfg_idx_i = 3'h0;
    logic [23:0] cs_cfg_base_i = 24'h00_0000, cs_cfg_top_i = 24'h00_0000;
    logic [5:0] chip_select_out_n_o;
    logic [2:0] bus_cfg_sel_o;
    logic half_rate_clock_out_o;
    int num_errors = 0, cmp_count = 0, cycles = 0;

    // clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // instances
    // ----------------------------------------
    bhcs_top i_bhcs_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .hold_req_n_i(hold_req_n_i),
        .hold_ack_out_n_o(hold_ack_out_n_o), .bus_request_out_n_o(bus_request_out_n_o),
        .hold_protocol_enable_i(hold_protocol_enable_i),
        .ext_cycle_pending_i(ext_cycle_pending_i), .ext_cycle_active_i(ext_cycle_active_i),
        .ext_addr_i(ext_addr_i), .port2_cfg_wr_i(port2_cfg_wr_i),
        .port2_function_select_i(p2_func), .port2_direction_i(port2_direction),
        .port2_output_latch_i(p2_latch), .port2_bit3_pin_o(port2_bit3_pin_o),
        .port2_bit3_pin_oe_o(port2_bit3_pin_oe_o), .cs_cfg_wr_i(cs_cfg_wr_i),
        .cs_cfg_idx_i(cs_cfg_idx_i), .cs_cfg_base_i(cs_cfg_base_i),
        .cs_cfg_top_i(cs_cfg_top_i), .cs_cfg_en_i(cs_cfg_en_i),
        .cs_cfg_remap_i(cs_cfg_remap_i), .chip_select_out_n_o(chip_select_out_n_o),
        .bus_cfg_sel_o(bus_cfg_sel_o), .half_rate_clock_out_o(half_rate_clock_out_o));
    bhcs_master_model i_bhcs_master_model (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .want_bus_i(want_bus), .hold_req_n_o(hold_req_n_i));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // one external cycle, then idle
    task automatic cs_acc(input logic [23:0] a, input logic [5:0] cs, input logic [2:0] sel);
        ext_cycle_active_i = 1'b1;
        ext_addr_i = a;
        @(negedge clock_i);
        chk(chip_select_out_n_o, cs);
        chk(bus_cfg_sel_o, sel);
        ext_cycle_active_i = 1'b0;
        @(negedge clock_i);
        chk(chip_select_out_n_o, 6'h3f);
        chk(bus_cfg_sel_o, 3'h5);
    endtask : cs_acc

    task automatic cfg_wr(input logic [2:0] i, input logic [23:0] b, input logic [23:0] t,
                          input logic rm);
        {cs_cfg_wr_i, cs_cfg_idx_i, cs_cfg_base_i, cs_cfg_top_i} = {1'b1, i, b, t};
        {cs_cfg_en_i, cs_cfg_remap_i} = {1'b1, rm};
        @(negedge clock_i);
        cs_cfg_wr_i = 1'b0;
    endtask : cfg_wr

    task automatic p2_wr(input logic f, input logic d, input logic l);
        {port2_cfg_wr_i, p2_func, port2_direction, p2_latch} = {1'b1, f, d, l};
        @(negedge clock_i);
        port2_cfg_wr_i = 1'b0;
    endtask : p2_wr

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_clock();
        logic prev;
        int highs;
        highs = 0;
        prev = half_rate_clock_out_o;
        repeat (8) begin
            @(negedge clock_i);
            chk(half_rate_clock_out_o, !prev);
            prev = half_rate_clock_out_o;
            highs += int'(half_rate_clock_out_o);
        end
        chk(24'(highs), 24'h00_0004);
        $display("test clock_out done");
    endtask : t_clock

    task automatic t_cs();
        cs_acc(24'hff_2000, 6'h3e, 3'h0);
        cs_acc(24'hff_20ff, 6'h3e, 3'h0);
        cs_acc(24'hff_2100, 6'h3f, 3'h5);
        cfg_wr(3'h1, 24'h10_0000, 24'h10_ffff, 1'b0);
        cs_acc(24'h10_ffff, 6'h3d, 3'h1);
        cs_acc(24'h11_0000, 6'h3f, 3'h5);
        cfg_wr(3'h0, 24'hff_2000, 24'hff_20ff, 1'b1);
        cs_acc(24'h10_0000, 6'h3c, 3'h1);
        cs_acc(24'hff_2000, 6'h3e, 3'h0);
        cfg_wr(3'h6, 24'h20_0000, 24'h20_ffff, 1'b0);
        cs_acc(24'h20_0000, 6'h3f, 3'h5);
        cfg_wr(3'h5, 24'h20_0000, 24'h20_ffff, 1'b0);
        cs_acc(24'h20_0000, 6'h1f, 3'h5);
        $display("test chip_select done");
    endtask : t_cs

    task automatic t_hold();
        int n;
        hold_protocol_enable_i = 1'b1;
        ext_cycle_active_i = 1'b1;
        want_bus = 1'b1;
        repeat (8) @(negedge clock_i);
        chk(hold_ack_out_n_o, 1'b1);
        ext_cycle_active_i = 1'b0;
        n = 0;
        while (hold_ack_out_n_o !== 1'b0 && n < 10) begin
            chk(bus_request_out_n_o, 1'b1);
            @(negedge clock_i);
            n++;
        end
        chk(hold_ack_out_n_o, 1'b0);
        chk(bus_request_out_n_o, 1'b1);
        ext_cycle_pending_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk(bus_request_out_n_o, 1'b0);
        chk(port2_bit3_pin_o, 1'b0);
        chk(port2_bit3_pin_oe_o, 1'b1);
        ext_cycle_pending_i = 1'b0;
        repeat (4) @(negedge clock_i);
        chk(bus_request_out_n_o, 1'b0);
        want_bus = 1'b0;
        n = 0;
        while (hold_ack_out_n_o !== 1'b1 && n < 10) begin
            chk(bus_request_out_n_o, 1'b0);
            @(negedge clock_i);
            n++;
        end
        chk(bus_request_out_n_o, 1'b1);
        hold_protocol_enable_i = 1'b0;
        $display("test hold done");
    endtask : t_hold

    task automatic t_port2();
        p2_wr(1'b0, 1'b1, 1'b0);
        repeat (2) @(negedge clock_i);
        chk({port2_bit3_pin_o, port2_bit3_pin_oe_o}, 2'h1);
        hold_protocol_enable_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({port2_bit3_pin_o, port2_bit3_pin_oe_o}, 2'h3);
        p2_wr(1'b0, 1'b0, 1'b1);
        hold_protocol_enable_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk({port2_bit3_pin_o, port2_bit3_pin_oe_o}, 2'h1);
        $display("test port2 done");
    endtask : t_port2

    // mid-run reset brings back the power-on ranges
    task automatic t_reset();
        rst_b_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk({hold_ack_out_n_o, bus_request_out_n_o, port2_bit3_pin_oe_o}, 3'h6);
        chk({chip_select_out_n_o, bus_cfg_sel_o, half_rate_clock_out_o}, 10'h3fa);
        rst_b_i = 1'b1;
        cs_acc(24'hff_20ff, 6'h3e, 3'h0);
        cs_acc(24'h10_0000, 6'h3f, 3'h5);
        $display("test reset done");
    endtask : t_reset

    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(negedge clock_i);
        chk({hold_ack_out_n_o, bus_request_out_n_o, port2_bit3_pin_oe_o}, 3'h6);
        chk({chip_select_out_n_o, bus_cfg_sel_o, half_rate_clock_out_o}, 10'h3fa);
        rst_b_i = 1'b1;
        t_clock();
        t_cs();
        t_hold();
        t_port2();
        t_reset();
        end_of_test();
    end
endmodule : bhcs_top_tb
